// *** range_class_id.v ***
`timescale 1ns/1ps
`include "range_class_regs.vh"
// address range class selector with an avalon-mm register slave
module range_class_id
(
  input  wire         CLK,
  input  wire         RST,
  // register bus
  input  wire [7:0]   ADDRESS,
  input  wire         READ,
  input  wire         WRITE,
  input  wire [31:0]  WRITEDATA,
  input  wire [3:0]   BYTEENABLE,
  output reg  [31:0]  READDATA,
  output reg          WAITREQUEST,
  input  wire         PRIVILEGED,
  output reg          PRIV_FAULT,
  // lookup from the load/store and fetch pipeline
  input  wire         LOOKUP_VALID,
  input  wire [63:0]  EFFECTIVE_ADDR,
  input  wire [1:0]   ACCESS_KIND,
  input  wire         LOOKUP_THREAD,
  input  wire         DATA_RELOCATE_FLAG,
  input  wire         FETCH_RELOCATE_FLAG,
  output reg          CLASS_VALID,
  output reg  [3:0]   CLASS_ID
);

  // register storage, one entry per thread and range
  reg  [51:0] start_addr [0:`ENTRIES-1];
  reg         reloc      [0:`ENTRIES-1];
  reg         valid      [0:`ENTRIES-1];
  reg  [19:0] mask       [0:`ENTRIES-1];
  reg  [3:0]  class_sel  [0:`ENTRIES-1];

  wire        req;
  wire        done;
  wire [2:0]  sel_entry;
  wire [2:0]  sel_word;
  wire        word_mapped;
  wire        is_data;
  wire        relocate_flag;
  wire [3:0]  class_part [0:`ENTRIES-1];
  reg  [3:0]  next_class;
  reg  [31:0] next_readdata;
  reg  [31:0] wmask;
  integer     k;
  integer     n;

  assign req = READ | WRITE;
  // the request completes on the edge where waitrequest stands low
  assign done = req & ~WAITREQUEST;
  assign sel_entry = {ADDRESS[`THREAD_BIT],
                      ADDRESS[`RANGE_LSB+1:`RANGE_LSB]};
  assign sel_word = ADDRESS[`RANGE_LSB-1:`WORD_LSB] == 3'h0 ? 3'h0 :
                    ADDRESS[`RANGE_LSB-1:`WORD_LSB];
  // word offsets 5..7 and unaligned addresses are unmapped
  assign word_mapped = (sel_word <= `WORD_CLASS) &
                       (ADDRESS[1:0] == 2'h0);

  // cache management operations count as data accesses
  assign is_data = (ACCESS_KIND != `KIND_FETCH); // [RQ11]
  assign relocate_flag = is_data ? DATA_RELOCATE_FLAG
                                 : FETCH_RELOCATE_FLAG; // [RQ8]

  // byte lane mask from byteenable
  always @*
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      wmask[k*8 +: 8] = {8{BYTEENABLE[k]}};
    end
  end

  // waitrequest drops for one cycle per request, then rises again
  always @(posedge CLK)
  begin
    if (RST)
    begin
      WAITREQUEST <= 1'b1;
    end
    else
    begin
      WAITREQUEST <= ~(req & WAITREQUEST);
    end
  end

  // one compare per entry; range bank and thread select the enable
  genvar g;
  generate
    for (g = 0; g < `ENTRIES; g = g + 1)
    begin : entry
      wire data_rng;
      wire wr_here;
      wire [31:0] old_hi;
      wire [31:0] old_lo;
      wire [31:0] new_hi;
      wire [31:0] new_lo;
      wire [31:0] old_mk;
      wire [31:0] new_mk;
      wire [31:0] new_cl;

      // ranges 0..1 serve fetches, 2..3 serve data, per thread
      assign data_rng = ((g % `RANGES) >= `FIRST_DATA_RNG); // [RQ2] [RQ3]
      // writes need privilege; otherwise the entry keeps its contents
      assign wr_here = done & WRITE & PRIVILEGED & word_mapped
                     & ({29'h0, sel_entry} == g); // [RQ14] [RQ17]
      assign old_hi = start_addr[g][51:20];
      assign old_lo = {start_addr[g][19:0], 10'h000,
                       reloc[g], valid[g]};
      assign new_hi = (old_hi & ~wmask) | (WRITEDATA & wmask);
      assign new_lo = (old_lo & ~wmask) | (WRITEDATA & wmask);
      assign old_mk = {mask[g], 12'h000};
      assign new_mk = (old_mk & ~wmask) | (WRITEDATA & wmask);
      assign new_cl = ({28'h0000000, class_sel[g]} & ~wmask)
                    | (WRITEDATA & wmask);

      // register write port, reserved bits are not stored
      always @(posedge CLK)
      begin
        if (RST)
        begin
          start_addr[g] <= `START_RST;
          reloc[g]      <= 1'b0;
          valid[g]      <= 1'b0;
          mask[g]       <= `MASK_RST;
          class_sel[g]  <= `CLASS_RST;
        end
        else if (wr_here)
        begin
          case (sel_word)
            `WORD_START_HI:
            begin
              start_addr[g][51:20] <= new_hi;
            end
            `WORD_START_LO:
            begin
              start_addr[g][19:0] <= new_lo[`ADDR_LO_MSB:`ADDR_LO_LSB];
              reloc[g] <= new_lo[`REL_BIT]; // [RQ15]
              valid[g] <= new_lo[`VALID_BIT]; // [RQ6]
            end
            `WORD_MASK_LO:
            begin
              mask[g] <= new_mk[`ADDR_LO_MSB:`ADDR_LO_LSB];
            end
            `WORD_CLASS:
            begin
              class_sel[g] <= new_cl[3:0];
            end
            default:
            begin
              mask[g] <= mask[g]; // upper mask half is fixed ones
            end
          endcase
        end
      end

      // each range is a start, mask and class select triple
      range_match u_match
      (
        .start_addr     (start_addr[g]),
        .reloc          (reloc[g]),
        .valid          (valid[g]),
        .mask           (mask[g]),
        .class_sel      (class_sel[g]),
        .effective_addr (EFFECTIVE_ADDR),
        .relocate_flag  (relocate_flag),
        .enable         ((data_rng == is_data) &
                         ((g / `RANGES) == {31'h0, LOOKUP_THREAD})), // [RQ3]
        .class_out      (class_part[g])
      ); // [RQ5]
    end
  endgenerate

  // overlapping hits merge by OR; no hit leaves zero
  always @*
  begin
    next_class = 4'h0; // [RQ10]
    for (n = 0; n < `ENTRIES; n = n + 1)
    begin
      next_class = next_class | class_part[n]; // [RQ12]
    end
  end

  // class output follows each lookup by one cycle
  always @(posedge CLK)
  begin
    if (RST)
    begin
      CLASS_VALID <= 1'b0;
      CLASS_ID    <= 4'h0;
    end
    else
    begin
      CLASS_VALID <= LOOKUP_VALID; // [RQ1]
      CLASS_ID    <= LOOKUP_VALID ? next_class : 4'h0; // [RQ9]
    end
  end

  // read mux; unprivileged or unmapped reads return zero
  always @*
  begin
    next_readdata = 32'h00000000;
    if (PRIVILEGED & word_mapped) // [RQ14]
    begin
      case (sel_word)
        `WORD_START_HI:
          next_readdata = start_addr[sel_entry][51:20];
        `WORD_START_LO:
          next_readdata = {start_addr[sel_entry][19:0], 10'h000,
                           reloc[sel_entry], valid[sel_entry]};
        `WORD_MASK_HI:
          next_readdata = `MASK_HI_READ; // reserved half reads ones
        `WORD_MASK_LO:
          next_readdata = {mask[sel_entry], 12'h000};
        `WORD_CLASS:
          next_readdata = {28'h0000000, class_sel[sel_entry]};
        default:
          next_readdata = 32'h00000000;
      endcase
    end
  end

  // read data is loaded as waitrequest drops, so it stands at completion
  always @(posedge CLK)
  begin
    if (RST)
    begin
      READDATA   <= 32'h00000000;
      PRIV_FAULT <= 1'b0;
    end
    else
    begin
      if (READ & WAITREQUEST)
      begin
        READDATA <= next_readdata;
      end
      // one-cycle pulse after an unprivileged access completes
      PRIV_FAULT <= done & ~PRIVILEGED; // [RQ17]
    end
  end

endmodule // range_class_id

// *** range_class_regs.vh ***
// Overview of operation
// RQ1: every load, store or fetch address yields a class ID for replacement.
// RQ2: two fetch ranges and two data ranges exist per logical processor.
// RQ3: the whole set of range registers is replicated per hardware thread.
// RQ4: software programs power-of-two sizes 4 KB..4 GB, start aligned to size.
// RQ5: each range has one start, one mask and one class select register.
// RQ6: a range hits only while its start register valid bit 63 is one.
// RQ7: compare address 0:31 plus (address 32:51 AND mask) against start 0:51.
// RQ8: start bit 62 must equal data or fetch relocate flag for the access.
// RQ9: a hitting range supplies its class select value as table index.
// RQ10: with no hitting range the class ID output is zero.
// RQ11: cache management operations are classified as data accesses.
// RQ12: several simultaneous hits give the OR of their class values.
// RQ13: software keeps ranges from overlapping to avoid merged class values.
// RQ14: range registers are reachable only by privileged register moves.
// RQ15: relocation bit clear means real addressing, set means virtual.
// RQ16: address upper half always compares; only bits 32..51 are maskable.
// RQ17: unprivileged access leaves registers unchanged and flags a violation.
`ifndef RANGE_CLASS_REGS_VH
`define RANGE_CLASS_REGS_VH

// geometry
`define THREADS        2
`define RANGES         4
`define ENTRIES        8
`define CID_W          4
`define ADDR_W         8

// byte address = {thread, range, word} << 2
`define THREAD_BIT     7
`define RANGE_LSB      5
`define WORD_LSB       2
`define WORD_START_HI  3'h0
`define WORD_START_LO  3'h1
`define WORD_MASK_HI   3'h2
`define WORD_MASK_LO   3'h3
`define WORD_CLASS     3'h4

// field positions inside the low words (little-endian bit numbers)
`define ADDR_LO_MSB    31
`define ADDR_LO_LSB    12
`define REL_BIT        1
`define VALID_BIT      0

// ranges 0..1 serve fetches, 2..3 serve data accesses
`define FIRST_DATA_RNG 2

// access kinds
`define KIND_LOAD      2'h0
`define KIND_STORE     2'h1
`define KIND_FETCH     2'h2
`define KIND_CACHEOP   2'h3

// reset values and fixed read values
`define START_RST      52'h0000000000000
`define MASK_RST       20'h00000
`define CLASS_RST      4'h0
`define MASK_HI_READ   32'hffffffff

`endif

// *** range_match.v ***
`timescale 1ns/1ps
// one address range compare; drives its class value only on a hit
module range_match
(
  input  wire [51:0]  start_addr,
  input  wire         reloc,
  input  wire         valid,
  input  wire [19:0]  mask,
  input  wire [3:0]   class_sel,
  input  wire [63:0]  effective_addr,
  input  wire         relocate_flag,
  input  wire         enable,
  output wire [3:0]   class_out
);

  wire [51:0] probe;
  wire        hit;

  // upper half compares unmasked, bits 32..51 are masked
  assign probe = {effective_addr[63:32],
                  effective_addr[31:12] & mask}; // [RQ7] [RQ16]
  // relocation mode must match real or virtual state of the access
  assign hit = enable & valid // [RQ6]
             & (reloc == relocate_flag) // [RQ8] [RQ15]
             & (probe == start_addr); // [RQ7]
  assign class_out = hit ? class_sel : 4'h0; // [RQ9] [RQ10]

endmodule // range_match

// *** range_class_id_asserts.sv ***
`timescale 1ns/1ps
// bus handshake, fault and lookup timing watched at the ports
module rci_chk
(
  input wire        CLK,
  input wire        RST,
  input wire        READ,
  input wire        WRITE,
  input wire        WAITREQUEST,
  input wire [31:0] READDATA,
  input wire        PRIVILEGED,
  input wire        PRIV_FAULT,
  input wire        LOOKUP_VALID,
  input wire        CLASS_VALID,
  input wire [3:0]  CLASS_ID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // a request completes at the edge where waitrequest is low
  wire rq = READ | WRITE;
  wire done = rq & ~WAITREQUEST;

  a_one_wait: assert property (rq && WAITREQUEST |=> !WAITREQUEST)
    else $error("bus request not answered after one wait");
  a_wait_pulse: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_lookup_ans: assert property (LOOKUP_VALID |=> CLASS_VALID)
    else $error("lookup without class answer");
  a_idle_zero: assert property (!LOOKUP_VALID |=> !CLASS_VALID
    && CLASS_ID == 4'h0)
    else $error("class output without lookup");
  a_fault_set: assert property (done && !PRIVILEGED |=> PRIV_FAULT)
    else $error("unprivileged access not flagged");
  a_fault_clear: assert property (done && PRIVILEGED |=> !PRIV_FAULT)
    else $error("privileged access flagged");
  a_fault_pulse: assert property ($rose(PRIV_FAULT)
    |-> ##1 !PRIV_FAULT)
    else $error("fault pulse longer than one cycle");
  a_read_blocked: assert property (READ && !WAITREQUEST
    && !PRIVILEGED |-> READDATA == 32'h0)
    else $error("unprivileged read returned data");
  c_fault: cover property (done && !PRIVILEGED);
  c_class: cover property (CLASS_VALID && CLASS_ID != 4'h0);
  c_read: cover property (READ && !WAITREQUEST);
endmodule // rci_chk

bind range_class_id rci_chk u_chk
(
  .CLK(CLK), .RST(RST), .READ(READ), .WRITE(WRITE),
  .WAITREQUEST(WAITREQUEST), .READDATA(READDATA),
  .PRIVILEGED(PRIVILEGED), .PRIV_FAULT(PRIV_FAULT),
  .LOOKUP_VALID(LOOKUP_VALID), .CLASS_VALID(CLASS_VALID),
  .CLASS_ID(CLASS_ID)
);

// *** core_pipe.sv ***
`timescale 1ns/1ps
// load/store and fetch pipeline issuing one lookup at a time
module core_pipe
(
  input  wire        clk,
  output reg         valid,
  output reg  [63:0] addr,
  output reg  [1:0]  kind,
  output reg         thread,
  output reg         data_reloc,
  output reg         fetch_reloc,
  input  wire        class_valid,
  input  wire [3:0]  class_id
);
  // quiet lines at start
  initial
  begin
    valid = 1'h0;
    addr = 64'h0;
    kind = 2'h0;
    thread = 1'h0;
    data_reloc = 1'h0;
    fetch_reloc = 1'h0;
  end
  // address is scrambled after use so a stale value never matches
  task look(input [63:0] a, input [1:0] k, input t, input d, input f,
            output [4:0] c);
  begin
    @(posedge clk);
    valid <= 1'h1;
    addr <= a;
    kind <= k; // kind passes through unchanged; cache ops go out as their own kind
    thread <= t;
    data_reloc <= d;
    fetch_reloc <= f;
    @(posedge clk);
    valid <= 1'h0;
    addr <= ~a;
    #1;
    c = {class_valid, class_id};
  end
  endtask
endmodule // core_pipe

// *** range_class_id_tb_top.sv ***
`timescale 1ns/1ps
// scenarios for the range class selector
module range_class_id_tb_top;
  reg         clk;
  reg         rst;
  reg  [7:0]  address;
  reg         read;
  reg         write;
  reg  [31:0] writedata;
  reg         priv;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        priv_fault;
  wire        lv, th, drf, frf, cv;
  wire [63:0] lk_addr;
  wire [1:0]  kd;
  wire [3:0]  cid;
  integer     errors, tests_run, i;
  reg  [31:0] q;
  reg  [4:0]  c;
  localparam [63:0] hit_a = 64'h0000000100123456;
  localparam [31:0] msk = 32'hfff00000;

  range_class_id DUT
  (
    .CLK(clk), .RST(rst), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(4'hf),
    .READDATA(readdata), .WAITREQUEST(waitrequest),
    .PRIVILEGED(priv), .PRIV_FAULT(priv_fault),
    .LOOKUP_VALID(lv), .EFFECTIVE_ADDR(lk_addr), .ACCESS_KIND(kd),
    .LOOKUP_THREAD(th), .DATA_RELOCATE_FLAG(drf),
    .FETCH_RELOCATE_FLAG(frf), .CLASS_VALID(cv), .CLASS_ID(cid)
  );
  core_pipe core
  (
    .clk(clk), .valid(lv), .addr(lk_addr), .kind(kd), .thread(th),
    .data_reloc(drf), .fetch_reloc(frf), .class_valid(cv), .class_id(cid)
  );

  // free-running clock
  always #25 clk = ~clk;

  task check(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  end
  endtask
  function [7:0] ad(input t, input [1:0] r, input [2:0] w);
    ad = {t, r, w, 2'h0};
  endfunction
  // request held until the edge that sees waitrequest low
  task bus(input w, input [7:0] a, input [31:0] d, input p,
           output [31:0] r);
  begin
    @(posedge clk);
    write <= w;
    read <= ~w;
    address <= a;
    writedata <= d;
    priv <= p;
    @(posedge clk);
    while (waitrequest !== 1'h0)
      @(posedge clk);
    r = readdata;
    read <= 1'h0;
    write <= 1'h0;
  end
  endtask
  task rd(input [7:0] a, input p, input [31:0] e);
  begin
    bus(1'h0, a, 32'h0, p, q);
    check(q, e);
  end
  endtask
  task prog(input t, input [1:0] r, input [31:0] lo, input [31:0] cl);
  begin
    bus(1'h1, ad(t, r, 3'h0), 32'h1, 1'h1, q);
    bus(1'h1, ad(t, r, 3'h1), lo, 1'h1, q);
    bus(1'h1, ad(t, r, 3'h3), msk, 1'h1, q);
    bus(1'h1, ad(t, r, 3'h4), cl, 1'h1, q);
  end
  endtask
  task lk(input [63:0] a, input [1:0] k, input t, input d, input f,
          input [3:0] e);
  begin
    core.look(a, k, t, d, f, c);
    check({27'h0, c}, {27'h0, 1'h1, e});
  end
  endtask

  task t_reset;
  begin
    lk(hit_a, 2'h0, 1'h0, 1'h1, 1'h1, 4'h0);
    rd(ad(1'h0, 2'h2, 3'h1), 1'h1, 32'h0);
    rd(ad(1'h0, 2'h2, 3'h2), 1'h1, 32'hffffffff);
  end
  endtask
  task t_match;
  begin
    prog(1'h0, 2'h2, 32'h00100003, 32'h5);
    for (i = 0; i < 4; i = i + 1)
      if (i != 2)
        lk(hit_a, i[1:0], 1'h0, 1'h1, 1'h0, 4'h5);
    lk(64'h00000001001ffffc, 2'h1, 1'h0, 1'h1, 1'h0, 4'h5);
    lk(hit_a, 2'h2, 1'h0, 1'h1, 1'h1, 4'h0);
    lk(hit_a, 2'h0, 1'h0, 1'h0, 1'h1, 4'h0);
    lk(64'h0000000200123456, 2'h0, 1'h0, 1'h1, 1'h1, 4'h0);
    lk(64'h0000000100223456, 2'h0, 1'h0, 1'h1, 1'h1, 4'h0);
    lk(hit_a, 2'h0, 1'h1, 1'h1, 1'h1, 4'h0);
  end
  endtask
  task t_fetch;
  begin
    prog(1'h0, 2'h0, 32'h00100001, 32'ha);
    lk(hit_a, 2'h2, 1'h0, 1'h1, 1'h0, 4'ha);
    lk(hit_a, 2'h2, 1'h0, 1'h0, 1'h1, 4'h0);
  end
  endtask
  task t_or;
  begin
    prog(1'h0, 2'h3, 32'h00100003, 32'h2);
    lk(hit_a, 2'h0, 1'h0, 1'h1, 1'h0, 4'h7);
    bus(1'h1, ad(1'h0, 2'h3, 3'h1), 32'h00100002, 1'h1, q);
    lk(hit_a, 2'h0, 1'h0, 1'h1, 1'h0, 4'h5);
  end
  endtask
  task t_priv;
  begin
    bus(1'h1, ad(1'h0, 2'h2, 3'h4), 32'h9, 1'h0, q);
    #1;
    check({31'h0, priv_fault}, 32'h1);
    rd(ad(1'h0, 2'h2, 3'h4), 1'h0, 32'h0);
    rd(ad(1'h0, 2'h2, 3'h4), 1'h1, 32'h5);
    rd(ad(1'h0, 2'h2, 3'h5), 1'h1, 32'h0);
  end
  endtask

  task final_report;
  begin
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // main sequence after a five-cycle reset
  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    address = 8'h0;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    priv = 1'h1;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_match;
    t_fetch;
    t_or;
    t_priv;
    final_report;
  end
  // a hung handshake is cut off well past the expected run
  initial
  begin
    #100000;
    errors = errors + 1;
    final_report;
  end
endmodule // range_class_id_tb_top
